// File: rx_fifo_port_pkg.sv
// constants shared by the endpoint receive fifo port
package rx_fifo_port_pkg;
  localparam int DATA_WIDTH = 8;
  localparam int EP_SEL_WIDTH = 3;
  localparam int NUM_ENDPOINTS = 5;
  localparam int STAGE_DEPTH = 4;
  localparam int MAX_PACKET_BYTES = 16;
  localparam int BYTE_COUNT_WIDTH = 5;
  localparam logic [7:0] ADDR_RECEIVE_FIFO_DATA = 8'hE3;
  localparam logic [7:0] ADDR_RECEIVE_FIFO_CONTROL = 8'hE4;
  localparam logic [7:0] ADDR_RECEIVE_FLAG_REG = 8'hE5;
  localparam logic [7:0] ADDR_RECEIVE_BYTE_COUNT = 8'hE6;
  localparam int CTRL_FLUSH_BIT = 7;
  localparam int CTRL_RELEASE_BIT = 4;
  localparam int CTRL_ISO_BIT = 3;
  localparam int FLAG_INDEX_BIT = 6;
  localparam int FLAG_EMPTY_BIT = 3;
  localparam int FLAG_FULL_BIT = 2;
  localparam int FLAG_UNDERFLOW_BIT = 1;
  localparam int FLAG_OVERFLOW_BIT = 0;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic [7:0] RESERVED_READ = 8'h00;
  localparam int READ_LATENCY = 2;
  typedef enum logic [2:0] {
    SRC_NONE,
    SRC_DATA,
    SRC_CAPTURED
  } read_src_type;
endpackage : rx_fifo_port_pkg

// File: rx_stage_fifo.sv
// small synchronous fifo with flush, registered read data
`timescale 1ns/1ps
module rx_stage_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic flush,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  input wire logic out_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  output logic full,
  output logic empty
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
    logic [WIDTH-1:0] dout;
  } fifo_state_type;

  fifo_state_type state;
  fifo_state_type next_state;
  logic push;
  logic pop;

  function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] ptr);
    if (ptr == PTR_W'(DEPTH - 1)) begin
      bump = '0;
    end else begin
      bump = ptr + PTR_W'(1);
    end
  endfunction : bump

  assign full = (state.count == CNT_W'(DEPTH));
  assign empty = (state.count == '0);
  assign in_ready = !full && !flush;
  assign out_valid = !empty;
  assign out_data = state.dout;
  assign push = in_valid && in_ready;
  assign pop = out_ready && !empty && !flush;

  always_comb begin
    next_state = state;
    if (flush) begin
      // pointers back to start, stored words dropped
      next_state.wr_ptr = '0;
      next_state.rd_ptr = '0;
      next_state.count = '0;
    end else begin
      if (push) begin
        next_state.mem[state.wr_ptr] = in_data;
        next_state.wr_ptr = bump(state.wr_ptr);
      end
      if (pop) begin
        next_state.dout = state.mem[state.rd_ptr];
        next_state.rd_ptr = bump(state.rd_ptr);
      end
      if (push && !pop) begin
        next_state.count = state.count + CNT_W'(1);
      end else if (pop && !push) begin
        next_state.count = state.count - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
endmodule : rx_stage_fifo

// File: rx_fifo_port.sv
// endpoint-indexed receive fifo port with its control, flag, count and data registers
//
// Notes on behaviour
// - every firmware access works on the fifo picked by the endpoint select input and leaves the others alone.
// - writing one to the flush bit (bit 7) of the control register throws away everything in the selected fifo.
// - a flush sets the empty flag and clears every other receive flag.
// - a flush puts all read and write pointers and packet markers of the selected fifo back to the start.
// - a flush never touches the data toggle sequence bit, which lives outside this block.
// - the flush bit clears itself when the flush is done, so firmware can poll it.
// - writing one to the read-complete bit (bit 4) releases the data set just read and clears its packet index flag.
// - the read-complete bit clears itself once the packet index flag has been cleared.
// - read-complete is ignored unless both start-overwrite and end-overwrite flags are clear.
// - the isochronous bit (bit 3) puts the selected fifo and the usb interface into isochronous mode.
// - a flush leaves the isochronous bit alone; only a firmware write changes it.
// - a byte written by the usb interface unit is stored and the write pointer moves on by itself.
// - each firmware read of the data register from a non-empty fifo gives the next stored byte and moves the read pointer on.
// - reserved bits read back as zero here and firmware writes zero to them.
// - the byte count register holds the size of the last received packet, never more than sixteen.
`timescale 1ns/1ps
module rx_fifo_port
  import rx_fifo_port_pkg::*;
#(
  parameter int NUM_EP = rx_fifo_port_pkg::NUM_ENDPOINTS,
  parameter int FIFO_DEPTH = rx_fifo_port_pkg::STAGE_DEPTH
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire logic [rx_fifo_port_pkg::DATA_WIDTH-1:0] SFR_WDATA,
  output logic [rx_fifo_port_pkg::DATA_WIDTH-1:0] SFR_RDATA,
  output logic SFR_RDATA_VALID,
  input wire logic [rx_fifo_port_pkg::EP_SEL_WIDTH-1:0] ENDPOINT_SELECT,
  input wire logic START_OVERWRITE,
  input wire logic END_OVERWRITE,
  input wire logic USB_WR_VALID,
  input wire logic [rx_fifo_port_pkg::EP_SEL_WIDTH-1:0] USB_WR_EP,
  input wire logic [rx_fifo_port_pkg::DATA_WIDTH-1:0] USB_WR_DATA,
  output logic USB_WR_READY,
  input wire logic USB_PACKET_END,
  output logic [NUM_EP-1:0] ISO_MODE
);
  import rx_fifo_port_pkg::*;

  localparam int CW = BYTE_COUNT_WIDTH;
  localparam int SW = EP_SEL_WIDTH;

  typedef struct packed {
    logic [NUM_EP-1:0] flush_pend;
    logic [NUM_EP-1:0] release_pend;
    logic [NUM_EP-1:0] iso;
    logic [NUM_EP-1:0] index_flag;
    logic [NUM_EP-1:0] overflow;
    logic [NUM_EP-1:0] underflow;
    logic [NUM_EP-1:0][CW-1:0] byte_acc;
    logic [NUM_EP-1:0][CW-1:0] byte_count;
    read_src_type rd_src;
    logic [SW-1:0] rd_ep;
    logic [DATA_WIDTH-1:0] captured;
    logic [DATA_WIDTH-1:0] rdata;
    logic rdata_valid;
  } port_state_type;

  port_state_type state;
  port_state_type next_state;

  logic [NUM_EP-1:0] fifo_flush;
  logic [NUM_EP-1:0] fifo_push;
  logic [NUM_EP-1:0] fifo_in_ready;
  logic [NUM_EP-1:0] fifo_pop;
  logic [NUM_EP-1:0] fifo_full;
  logic [NUM_EP-1:0] fifo_empty;
  logic [NUM_EP-1:0][DATA_WIDTH-1:0] fifo_dout;
  logic sel_ok;
  logic usb_ep_ok;
  logic fw_data_read;
  logic fw_ctrl_write;

  // true when the index addresses endpoint number ep
  function automatic logic ep_hit(input logic [SW-1:0] idx, input int ep);
    ep_hit = (int'(idx) == ep);
  endfunction : ep_hit

  // true when the index names an existing endpoint
  function automatic logic ep_exists(input logic [SW-1:0] idx);
    ep_exists = (int'(idx) < NUM_EP);
  endfunction : ep_exists

  assign sel_ok = ep_exists(ENDPOINT_SELECT);
  assign usb_ep_ok = ep_exists(USB_WR_EP);
  assign fw_data_read = SFR_RD && (SFR_ADDR == ADDR_RECEIVE_FIFO_DATA) && sel_ok;
  assign fw_ctrl_write = SFR_WR && (SFR_ADDR == ADDR_RECEIVE_FIFO_CONTROL) && sel_ok;

  genvar g;
  generate
    for (g = 0; g < NUM_EP; g++) begin : gen_ep
      assign fifo_flush[g] = state.flush_pend[g];
      assign fifo_push[g] = USB_WR_VALID && ep_hit(USB_WR_EP, g);
      assign fifo_pop[g] = fw_data_read && ep_hit(ENDPOINT_SELECT, g);
      rx_stage_fifo #(
        .WIDTH(DATA_WIDTH),
        .DEPTH(FIFO_DEPTH)
      ) u_fifo (
        .CORE_CLK(CORE_CLK),
        .RESETN(RESETN),
        .flush(fifo_flush[g]),
        .in_valid(fifo_push[g]),
        .in_data(USB_WR_DATA),
        .in_ready(fifo_in_ready[g]),
        .out_ready(fifo_pop[g]),
        .out_valid(),
        .out_data(fifo_dout[g]),
        .full(fifo_full[g]),
        .empty(fifo_empty[g])
      );
    end
  endgenerate

  // back-pressure to the usb interface unit; bytes for a missing endpoint are dropped
  always_comb begin
    USB_WR_READY = 1'b1;
    if (usb_ep_ok) begin
      USB_WR_READY = fifo_in_ready[USB_WR_EP];
    end
  end

  assign ISO_MODE = state.iso;
  assign SFR_RDATA = state.rdata;
  assign SFR_RDATA_VALID = state.rdata_valid;

  always_comb begin
    logic [DATA_WIDTH-1:0] reg_view;
    logic [CW-1:0] acc;
    next_state = state;
    reg_view = RESERVED_READ;
    acc = '0;

    for (int i = 0; i < NUM_EP; i++) begin
      acc = state.byte_acc[i];
      // count bytes of the packet being received, saturating at the packet maximum
      if (fifo_push[i] && fifo_in_ready[i] && acc != CW'(MAX_PACKET_BYTES)) begin
        acc = acc + CW'(1);
      end
      next_state.byte_acc[i] = acc;

      // release of the data set read by firmware, then self-clear
      if (state.release_pend[i]) begin
        if (state.index_flag[i]) begin
          next_state.index_flag[i] = 1'b0;
        end else begin
          next_state.underflow[i] = 1'b1;
        end
        next_state.release_pend[i] = 1'b0;
      end

      // end of packet marks a data set and latches its byte count
      if (USB_PACKET_END && ep_hit(USB_WR_EP, i)) begin
        if (state.index_flag[i] && !state.release_pend[i] && !state.iso[i]) begin
          next_state.overflow[i] = 1'b1;
        end
        next_state.index_flag[i] = 1'b1;
        next_state.byte_count[i] = acc;
        next_state.byte_acc[i] = '0;
      end

      // reading an empty fifo
      if (fifo_pop[i] && fifo_empty[i]) begin
        next_state.underflow[i] = 1'b1;
      end

      // flush: flags to reset state, markers to start, iso untouched, bit self-clears
      if (state.flush_pend[i]) begin
        next_state.index_flag[i] = 1'b0;
        next_state.overflow[i] = 1'b0;
        next_state.underflow[i] = 1'b0;
        next_state.byte_acc[i] = '0;
        next_state.byte_count[i] = '0;
        next_state.release_pend[i] = 1'b0;
        next_state.flush_pend[i] = 1'b0;
      end
    end

    // firmware write to the control register of the selected endpoint
    if (fw_ctrl_write) begin
      next_state.iso[ENDPOINT_SELECT] = SFR_WDATA[CTRL_ISO_BIT];
      if (SFR_WDATA[CTRL_FLUSH_BIT]) begin
        next_state.flush_pend[ENDPOINT_SELECT] = 1'b1;
      end else if (SFR_WDATA[CTRL_RELEASE_BIT] && !START_OVERWRITE && !END_OVERWRITE) begin
        next_state.release_pend[ENDPOINT_SELECT] = 1'b1;
      end
    end

    // register view of the selected endpoint, reserved bits as zero
    if (sel_ok) begin
      case (SFR_ADDR)
        ADDR_RECEIVE_FIFO_CONTROL: begin
          reg_view[CTRL_FLUSH_BIT] = state.flush_pend[ENDPOINT_SELECT];
          reg_view[CTRL_RELEASE_BIT] = state.release_pend[ENDPOINT_SELECT];
          reg_view[CTRL_ISO_BIT] = state.iso[ENDPOINT_SELECT];
        end
        ADDR_RECEIVE_FLAG_REG: begin
          reg_view[FLAG_INDEX_BIT] = state.index_flag[ENDPOINT_SELECT];
          reg_view[FLAG_EMPTY_BIT] = fifo_empty[ENDPOINT_SELECT];
          reg_view[FLAG_FULL_BIT] = fifo_full[ENDPOINT_SELECT];
          reg_view[FLAG_UNDERFLOW_BIT] = state.underflow[ENDPOINT_SELECT];
          reg_view[FLAG_OVERFLOW_BIT] = state.overflow[ENDPOINT_SELECT];
        end
        ADDR_RECEIVE_BYTE_COUNT: begin
          reg_view[CW-1:0] = state.byte_count[ENDPOINT_SELECT];
        end
        default: begin
          reg_view = RESERVED_READ;
        end
      endcase
    end

    // two-stage read answer: stage one pops or captures, stage two drives the bus
    next_state.rdata_valid = 1'b0;
    next_state.rd_src = SRC_NONE;
    if (SFR_RD) begin
      next_state.rd_ep = ENDPOINT_SELECT;
      next_state.captured = reg_view;
      next_state.rd_src = fw_data_read ? SRC_DATA : SRC_CAPTURED;
    end
    case (state.rd_src)
      SRC_DATA: begin
        next_state.rdata = fifo_dout[state.rd_ep];
        next_state.rdata_valid = 1'b1;
      end
      SRC_CAPTURED: begin
        next_state.rdata = state.captured;
        next_state.rdata_valid = 1'b1;
      end
      SRC_NONE: begin
        next_state.rdata = state.rdata;
      end
      default: begin
        next_state.rdata = state.rdata;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      state <= '0;
      state.rdata <= RDATA_RESET;
    end else begin
      state <= next_state;
    end
  end
endmodule : rx_fifo_port

// File: rx_fifo_port_props.sv
// pin-level assertions for the receive fifo port
`timescale 1ns/1ps
module rx_fifo_port_props
  import rx_fifo_port_pkg::*;
#(
  parameter int NUM_EP = 5
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_WDATA,
  input wire logic [7:0] SFR_RDATA,
  input wire logic SFR_RDATA_VALID,
  input wire logic [2:0] ENDPOINT_SELECT,
  input wire logic START_OVERWRITE,
  input wire logic END_OVERWRITE,
  input wire logic USB_WR_VALID,
  input wire logic [2:0] USB_WR_EP,
  input wire logic [7:0] USB_WR_DATA,
  input wire logic USB_WR_READY,
  input wire logic USB_PACKET_END,
  input wire logic [NUM_EP-1:0] ISO_MODE
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  logic wc;
  logic rc;
  assign wc = SFR_WR && SFR_ADDR == ADDR_RECEIVE_FIFO_CONTROL && int'(ENDPOINT_SELECT) < NUM_EP;
  assign rc = SFR_RD && SFR_ADDR == ADDR_RECEIVE_FIFO_CONTROL;
  AST_RD_LATENCY: assert property (SFR_RD |-> ##2 SFR_RDATA_VALID) else $error("late read answer");
  AST_VALID_CAUSE: assert property (SFR_RDATA_VALID |-> $past(SFR_RD, 2)) else $error("stray answer");
  AST_ISO_WRITE: assert property (wc |=> ISO_MODE[$past(ENDPOINT_SELECT)] == $past(SFR_WDATA[3]))
    else $error("iso bit not written");
  AST_ISO_HOLD: assert property (!wc |=> $stable(ISO_MODE)) else $error("iso bit moved");
  AST_FLUSH_READY: assert property (wc && SFR_WDATA[7] ##1 USB_WR_EP == $past(ENDPOINT_SELECT) |-> !USB_WR_READY)
    else $error("ready during flush");
  AST_SELF_CLEAR: assert property (wc ##2 (rc && $stable(ENDPOINT_SELECT)) |-> ##2 SFR_RDATA[7:4] == 4'h0)
    else $error("control bit stuck");
  AST_CTRL_RSVD: assert property (rc |-> ##2 (SFR_RDATA & 8'h67) == 8'h00) else $error("control rsvd");
  AST_FLAG_RSVD: assert property (SFR_RD && SFR_ADDR == ADDR_RECEIVE_FLAG_REG |-> ##2 (SFR_RDATA & 8'hB0) == 8'h00)
    else $error("flag rsvd");
  AST_COUNT_MAX: assert property (SFR_RD && SFR_ADDR == ADDR_RECEIVE_BYTE_COUNT |-> ##2 SFR_RDATA <= 8'h10)
    else $error("count too big");
  AST_UNMAPPED: assert property (SFR_RD && (SFR_ADDR < 8'hE3 || SFR_ADDR > 8'hE6 || int'(ENDPOINT_SELECT) >= NUM_EP)
    |-> ##2 SFR_RDATA == 8'h00) else $error("unmapped read");
endmodule : rx_fifo_port_props
bind rx_fifo_port rx_fifo_port_props #(.NUM_EP(NUM_EP)) u_props (.*);

// File: usb_unit_model.sv
// usb interface unit model pushing bytes and packet ends
`timescale 1ns/1ps
module usb_unit_model (
  input wire logic clk,
  input wire logic ready,
  output logic valid,
  output logic [2:0] ep,
  output logic [7:0] data,
  output logic pend
);
  initial begin
    valid = 1'b0;
    ep = 3'h0;
    data = 8'h00;
    pend = 1'b0;
  end
  // byte held until ready is seen before a rising edge, for at most eight cycles
  task automatic send(input logic [2:0] e, input logic [7:0] b, output bit ok);
    int n;
    @(negedge clk);
    valid = 1'b1;
    ep = e;
    data = b;
    ok = 1'b0;
    for (n = 0; n < 8 && !ok; n++) begin
      #1 ok = ready;
      @(negedge clk);
    end
    valid = 1'b0;
    data = ~b;
  endtask : send
  task automatic close(input logic [2:0] e);
    @(negedge clk);
    ep = e;
    pend = 1'b1;
    @(negedge clk);
    pend = 1'b0;
  endtask : close
endmodule : usb_unit_model

// File: testbench.sv
// self-checking bench for the receive fifo port
`timescale 1ns/1ps
module testbench;
  import rx_fifo_port_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [2:0] sel = 3'h0;
  logic so = 1'b0;
  logic eo = 1'b0;
  logic [7:0] rdata;
  logic rvalid;
  logic uvalid;
  logic upend;
  logic uready;
  logic [2:0] uep;
  logic [7:0] udata;
  logic [4:0] iso_mode;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [7:0] q[5][$];
  bit idx[5], un[5], ov[5], iso[5];
  int cnt[5], pn[5];
  logic [31:0] seed = 32'h0000_89D9;
  always #50 clk = ~clk;
  rx_fifo_port dut (.CORE_CLK(clk), .RESETN(rstn), .SFR_ADDR(addr), .SFR_WR(wr), .SFR_RD(rd),
    .SFR_WDATA(wdata), .SFR_RDATA(rdata), .SFR_RDATA_VALID(rvalid), .ENDPOINT_SELECT(sel),
    .START_OVERWRITE(so), .END_OVERWRITE(eo), .USB_WR_VALID(uvalid), .USB_WR_EP(uep),
    .USB_WR_DATA(udata), .USB_WR_READY(uready), .USB_PACKET_END(upend), .ISO_MODE(iso_mode));
  usb_unit_model u_usb (.clk(clk), .ready(uready), .valid(uvalid), .ep(uep), .data(udata), .pend(upend));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  task automatic close_out();
    if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    int n;
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    for (n = 0; n < 4 && rvalid !== 1'b1; n++) @(negedge clk);
    v = rvalid === 1'b1 ? rdata : 8'hxx;
  endtask : rd_reg
  task automatic check_ep(input int e);
    logic [7:0] v;
    sel = e[2:0];
    rd_reg(ADDR_RECEIVE_FIFO_CONTROL, v);
    chk("control", {4'h0, iso[e], 3'h0}, v);
    rd_reg(ADDR_RECEIVE_FLAG_REG, v);
    chk("flags", {1'b0, idx[e], 2'b00, q[e].size() == 0, q[e].size() == 4, un[e], ov[e]}, v);
    rd_reg(ADDR_RECEIVE_BYTE_COUNT, v);
    chk("count", cnt[e][7:0], v);
    chk("iso mode", {7'h0, iso[e]}, {7'h0, iso_mode[e]});
  endtask : check_ep
  task automatic push(input int e, input int n);
    logic [7:0] b;
    bit ok;
    repeat (n) begin
      b = rnd();
      u_usb.send(e[2:0], b, ok);
      chk("ready", {7'h0, q[e].size() < 4}, {7'h0, ok});
      if (ok) begin
        q[e].push_back(b);
        pn[e]++;
      end
    end
    u_usb.close(e[2:0]);
    if (idx[e] && !iso[e]) ov[e] = 1'b1;
    idx[e] = 1'b1;
    cnt[e] = pn[e] > 16 ? 16 : pn[e];
    pn[e] = 0;
  endtask : push
  task automatic pop(input int e, input int n);
    logic [7:0] v;
    sel = e[2:0];
    repeat (n) begin
      rd_reg(ADDR_RECEIVE_FIFO_DATA, v);
      if (q[e].size() == 0) un[e] = 1'b1;
      else chk("data", q[e].pop_front(), v);
    end
  endtask : pop
  task automatic ctrl(input int e, input logic [7:0] d);
    sel = e[2:0];
    wr_reg(ADDR_RECEIVE_FIFO_CONTROL, d);
    iso[e] = d[3];
    if (d[7]) begin
      q[e].delete();
      idx[e] = 1'b0;
      un[e] = 1'b0;
      ov[e] = 1'b0;
      cnt[e] = 0;
      pn[e] = 0;
    end else if (d[4] && !so && !eo) begin
      if (!idx[e]) un[e] = 1'b1;
      idx[e] = 1'b0;
    end
  endtask : ctrl
  initial begin
    int e;
    logic [7:0] v;
    logic [7:0] b;
    bit ok;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    for (e = 0; e < 5; e++) check_ep(e);
    sel = 3'h5;
    rd_reg(ADDR_RECEIVE_FLAG_REG, v);
    chk("high endpoint", 8'h00, v);
    u_usb.send(3'h5, rnd(), ok);
    chk("ready missing endpoint", 8'h01, {7'h0, ok});
    u_usb.close(3'h5);
    sel = 3'h1;
    rd_reg(8'hE7, v);
    chk("unmapped", 8'h00, v);
    wr_reg(ADDR_RECEIVE_FLAG_REG, 8'hFF);
    check_ep(1);
    push(2, 3);
    ctrl(2, 8'h08);
    push(2, 2);
    check_ep(2);
    ctrl(2, 8'h98);
    check_ep(2);
    pop(2, 1);
    check_ep(2);
    // long packet drained while it arrives, count saturates
    for (int k = 0; k < 18; k++) begin
      b = rnd();
      u_usb.send(3'h0, b, ok);
      chk("ready", 8'h01, {7'h0, ok});
      q[0].push_back(b);
      pn[0]++;
      pop(0, 1);
    end
    push(0, 0);
    check_ep(0);
    for (int k = 0; k < 16; k++) begin
      e = rnd() % 5;
      push(e, 1 + rnd() % 6);
      check_ep(e);
      check_ep((e + 1) % 5);
      pop(e, q[e].size() + rnd() % 2);
      so = (rnd() & 8'h07) == 0;
      eo = (rnd() & 8'h07) == 0;
      ctrl(e, rnd() & 8'h98);
      check_ep(e);
    end
    close_out();
  end
endmodule : testbench
